// >>> rtl/svmc_map.svh
// svmc_map.svh: register offsets, field positions, reset values and timing figures
// assumes: included by the supply monitor package and modules, by bare name
`ifndef SVMC_MAP_SVH
`define SVMC_MAP_SVH

// byte addresses on the register bus
`define SVMC_ADDR_W 12
`define SVMC_OFS_CTL 12'h030
`define SVMC_OFS_LVL 12'h034
`define SVMC_OFS_CFG 12'h038
`define SVMC_OFS_STAT 12'h03C

// monitor_comparator_control fields
`define SVMC_CTL_RST 8'h00
`define SVMC_CTL_CMP1_INV 0
`define SVMC_CTL_CMP2_INV 1
`define SVMC_CTL_CMP1_OE 2
`define SVMC_CTL_CMP2_OE 3
`define SVMC_CTL_CH1_TYPE 4
`define SVMC_CTL_CH2_TYPE 5
`define SVMC_CTL_GATE 7

// ch1 level select register
`define SVMC_LVL_RST 4'h0

// channel configuration register fields
`define SVMC_CFG_W 11
`define SVMC_CFG_RST 11'h000
`define SVMC_CFG_CH1_EN 0
`define SVMC_CFG_CH2_EN 1
`define SVMC_CFG_CH2_SRC 2
`define SVMC_CFG_CH1_BOTH 3
`define SVMC_CFG_CH2_BOTH 4
`define SVMC_CFG_CH1_RISE 5
`define SVMC_CFG_CH2_RISE 6
`define SVMC_CFG_CH1_FILT 7
`define SVMC_CFG_CH2_FILT 8
`define SVMC_CFG_DIV_LO 9
`define SVMC_CFG_DIV_HI 10

// status register fields
`define SVMC_STAT_CH1_LVL 0
`define SVMC_STAT_CH2_LVL 1

// filter timing: samples that must agree, divider counter width
`define SVMC_FILT_SAMPLES 2
`define SVMC_DIV_CNT_W 3

`endif

// >>> rtl/svmc_pkg.sv
// svmc_pkg.sv: types shared by the supply monitor control block
// assumes: svmc_map.svh on the include path
`include "svmc_map.svh"

package svmc_pkg;

    // filter clock divisor select, 1/2/4/8
    typedef enum logic [1:0] {
        SVMC_DIV1,
        SVMC_DIV2,
        SVMC_DIV4,
        SVMC_DIV8
    } svmc_div_e;

    // bus address slice
    typedef logic [`SVMC_ADDR_W-1:0] svmc_addr_t;

endpackage : svmc_pkg

// >>> rtl/svmc_sync.sv
// svmc_sync.sv: two-flop synchroniser for a group of independent levels
// assumes: each bit is a slow level from the analog side or a pin
`timescale 1ns/1ps

module svmc_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_ff; // first stage, read only by the second
    logic [W-1:0] sync_ff; // second stage

    // two flops per bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // reset to one: detectors read above threshold, so release gives no false crossing or reset
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : svmc_sync

// >>> rtl/svmc_filt.sv
// svmc_filt.sv: optional two-sample digital filter on one detector level
// assumes: din already synchronised, tick is a one-cycle sample strobe
`timescale 1ns/1ps

module svmc_filt (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic din,
    input wire logic filt_en,
    input wire logic tick,
    output logic level
);

    logic samp_ff; // last sample taken
    logic level_ff; // accepted level, above threshold after reset

    // bypass passes the level straight; filter accepts on two agreeing samples
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_ff <= 1'b1;
            level_ff <= 1'b1;
        end else if (!filt_en) begin
            samp_ff <= din;
            level_ff <= din;
        end else if (tick) begin
            samp_ff <= din;
            if (samp_ff == din) begin
                level_ff <= din;
            end
        end
    end

    assign level = level_ff;

endmodule : svmc_filt

// >>> rtl/svmc_top.sv
// svmc_top.sv: digital control of a three-channel supply voltage monitor
// assumes: AHB-Lite single-word slave, analog detectors give 1 when above threshold
`timescale 1ns/1ps
`include "svmc_map.svh"

module svmc_top
    import svmc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog and pin side
    input wire logic slow_osc_clock,
    input wire logic [1:0] option_config_byte,
    input wire logic ch0_det,
    input wire logic ch1_det,
    input wire logic ch2_det_supply,
    input wire logic ch2_det_ext,
    output logic [1:0] ch0_threshold,
    output logic [3:0] ch1_threshold,
    output logic ch2_source_sel,
    output logic sys_reset_req,
    output logic ch1_nmi_req,
    output logic ch1_mirq_req,
    output logic ch2_nmi_req,
    output logic ch2_mirq_req,
    output logic cmp1_out_pin,
    output logic cmp1_out_pin_oe,
    output logic cmp2_out_pin,
    output logic cmp2_out_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers and slow clock sampling tick
    ////////////////////////////////////////////////////////////////////////

    logic [4:0] sync_w; // {osc, ch2 pin, ch2 supply, ch1, ch0}
    logic osc_d_ff; // delayed synced oscillator for edge detect
    logic [`SVMC_DIV_CNT_W-1:0] div_cnt_ff; // divided-period counter
    logic [`SVMC_DIV_CNT_W-1:0] div_last_w; // terminal count n-1
    logic osc_rise_w; // one slow clock edge seen
    logic tick_w; // one divided period elapsed

    svmc_sync #(.W(5)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({slow_osc_clock, ch2_det_ext, ch2_det_supply, ch1_det, ch0_det}),
        .sync_out(sync_w)
    );

    logic [`SVMC_CFG_W-1:0] cfg_ff; // channel configuration
    svmc_div_e div_sel_w; // selected divisor

    assign div_sel_w = svmc_div_e'(cfg_ff[`SVMC_CFG_DIV_HI:`SVMC_CFG_DIV_LO]);
    assign osc_rise_w = sync_w[4] & ~osc_d_ff;
    // divisor 1, 2, 4 or 8
    assign div_last_w = (div_sel_w == SVMC_DIV8) ? 3'h7 :
                        (div_sel_w == SVMC_DIV4) ? 3'h3 :
                        (div_sel_w == SVMC_DIV2) ? 3'h1 : 3'h0;
    assign tick_w = osc_rise_w & (div_cnt_ff >= div_last_w);

    // divider counts slow clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // matches the synchroniser reset level, no false slow edge on release
            osc_d_ff <= 1'b1;
            div_cnt_ff <= '0;
        end else begin
            osc_d_ff <= sync_w[4];
            if (tick_w) begin
                div_cnt_ff <= '0;
            end else if (osc_rise_w) begin
                div_cnt_ff <= div_cnt_ff + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and bus slave
    ////////////////////////////////////////////////////////////////////////

    logic [7:0] ctl_ff; // monitor_comparator_control
    logic [3:0] lvl_ff; // ch1_level_select_reg
    logic [7:0] nxt_ctl_ff;
    logic [3:0] nxt_lvl_ff;
    logic [`SVMC_CFG_W-1:0] nxt_cfg_ff;
    logic wr_pend_ff; // write data phase pending
    svmc_addr_t wr_addr_ff; // address of pending write
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic acc_w; // address phase taken
    logic wr_ctl_w, wr_lvl_w, wr_cfg_w; // data-phase write strobes
    logic [31:0] rd_mux_w; // read value for the address in flight
    svmc_addr_t rd_addr_w;
    logic ch1_flag_w, ch2_flag_w; // level flags

    assign acc_w = hsel & htrans[1] & hready;
    assign rd_addr_w = haddr[`SVMC_ADDR_W-1:0];
    assign wr_ctl_w = wr_pend_ff & (wr_addr_ff == `SVMC_OFS_CTL);
    assign wr_lvl_w = wr_pend_ff & (wr_addr_ff == `SVMC_OFS_LVL);
    assign wr_cfg_w = wr_pend_ff & (wr_addr_ff == `SVMC_OFS_CFG);
    // reserved bit 6 held at zero
    assign nxt_ctl_ff = wr_ctl_w ? (hwdata[7:0] & 8'hBF) : ctl_ff;
    assign nxt_lvl_ff = wr_lvl_w ? hwdata[3:0] : lvl_ff;
    assign nxt_cfg_ff = wr_cfg_w ? hwdata[`SVMC_CFG_W-1:0] : cfg_ff;

    // read mux uses next values so a read right after a write sees it
    assign rd_mux_w = (rd_addr_w == `SVMC_OFS_CTL) ? {24'h00_0000, nxt_ctl_ff} :
                      (rd_addr_w == `SVMC_OFS_LVL) ? {28'h000_0000, nxt_lvl_ff} :
                      (rd_addr_w == `SVMC_OFS_CFG) ? {21'h0_0000, nxt_cfg_ff} :
                      (rd_addr_w == `SVMC_OFS_STAT) ? {30'h0, ch2_flag_w, ch1_flag_w} :
                      32'h0000_0000;

    // address phase capture and zero-wait answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            wr_pend_ff <= acc_w & hwrite;
            if (acc_w) begin
                wr_addr_ff <= rd_addr_w;
            end
            if (acc_w & ~hwrite) begin
                hrdata_ff <= rd_mux_w;
            end
        end
    end

    // register file, control resets to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_ff <= `SVMC_CTL_RST;
            lvl_ff <= `SVMC_LVL_RST;
            cfg_ff <= `SVMC_CFG_RST;
        end else begin
            ctl_ff <= nxt_ctl_ff;
            lvl_ff <= nxt_lvl_ff;
            cfg_ff <= nxt_cfg_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel 0: strap capture and reset
    ////////////////////////////////////////////////////////////////////////

    logic strap_done_ff; // strap caught once after release
    logic [1:0] ch0_thr_ff;
    logic sys_rst_ff;

    // option byte caught once, program cannot change it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_ff <= 1'b0;
            ch0_thr_ff <= 2'h0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            ch0_thr_ff <= option_config_byte;
        end
    end

    // reset held while supply below ch0 threshold, no filter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_rst_ff <= 1'b0;
        end else begin
            sys_rst_ff <= ~sync_w[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channels 1 and 2: filter, flags, crossing interrupts
    ////////////////////////////////////////////////////////////////////////

    logic ch1_en_w, ch2_en_w;
    logic ch2_raw_w; // selected ch2 source
    logic lvl1_w, lvl2_w; // accepted levels
    logic lvl1_d_ff, lvl2_d_ff;
    logic rise1_w, fall1_w, rise2_w, fall2_w;
    logic hit1_w, hit2_w; // crossing selected for interrupt
    logic mask1_w, mask2_w; // maskable type in force
    logic ch1_nmi_ff, ch1_mirq_ff, ch2_nmi_ff, ch2_mirq_ff;

    assign ch1_en_w = cfg_ff[`SVMC_CFG_CH1_EN];
    assign ch2_en_w = cfg_ff[`SVMC_CFG_CH2_EN];
    // ch2 source mux; 0 supply, 1 pin
    assign ch2_raw_w = cfg_ff[`SVMC_CFG_CH2_SRC] ? sync_w[3] : sync_w[2];

    // switchable filters on ch1 and ch2
    svmc_filt u_filt1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(sync_w[1]),
        .filt_en(cfg_ff[`SVMC_CFG_CH1_FILT]),
        .tick(tick_w),
        .level(lvl1_w)
    );

    svmc_filt u_filt2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(ch2_raw_w),
        .filt_en(cfg_ff[`SVMC_CFG_CH2_FILT]),
        .tick(tick_w),
        .level(lvl2_w)
    );

    assign ch1_flag_w = lvl1_w;
    // ch2 flag; reads one while disabled
    assign ch2_flag_w = ch2_en_w ? lvl2_w : 1'b1;

    // edges taken on the accepted level
    assign rise1_w = lvl1_w & ~lvl1_d_ff;
    assign fall1_w = ~lvl1_w & lvl1_d_ff;
    assign rise2_w = lvl2_w & ~lvl2_d_ff;
    assign fall2_w = ~lvl2_w & lvl2_d_ff;
    assign hit1_w = ch1_en_w & (cfg_ff[`SVMC_CFG_CH1_BOTH] ? (rise1_w | fall1_w) :
                    (cfg_ff[`SVMC_CFG_CH1_RISE] ? rise1_w : fall1_w));
    assign hit2_w = ch2_en_w & (cfg_ff[`SVMC_CFG_CH2_BOTH] ? (rise2_w | fall2_w) :
                    (cfg_ff[`SVMC_CFG_CH2_RISE] ? rise2_w : fall2_w));
    // type bits count only while gate is set
    assign mask1_w = ctl_ff[`SVMC_CTL_GATE] & ctl_ff[`SVMC_CTL_CH1_TYPE];
    assign mask2_w = ctl_ff[`SVMC_CTL_GATE] & ctl_ff[`SVMC_CTL_CH2_TYPE];

    // one-cycle request pulses per crossing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl1_d_ff <= 1'b1;
            lvl2_d_ff <= 1'b1;
            ch1_nmi_ff <= 1'b0;
            ch1_mirq_ff <= 1'b0;
            ch2_nmi_ff <= 1'b0;
            ch2_mirq_ff <= 1'b0;
        end else begin
            lvl1_d_ff <= lvl1_w;
            lvl2_d_ff <= lvl2_w;
            ch1_nmi_ff <= hit1_w & ~mask1_w;
            ch1_mirq_ff <= hit1_w & mask1_w;
            ch2_nmi_ff <= hit2_w & ~mask2_w;
            ch2_mirq_ff <= hit2_w & mask2_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparator output pins
    ////////////////////////////////////////////////////////////////////////

    logic cmp1_pin_ff, cmp1_oe_ff, cmp2_pin_ff, cmp2_oe_ff;

    // pins follow the raw synced result with optional inversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp1_pin_ff <= 1'b0;
            cmp1_oe_ff <= 1'b0;
            cmp2_pin_ff <= 1'b0;
            cmp2_oe_ff <= 1'b0;
        end else begin
            cmp1_pin_ff <= sync_w[1] ^ ctl_ff[`SVMC_CTL_CMP1_INV];
            cmp2_pin_ff <= ch2_raw_w ^ ctl_ff[`SVMC_CTL_CMP2_INV];
            // pin driven only in comparator use
            cmp1_oe_ff <= ctl_ff[`SVMC_CTL_CMP1_OE] & ~ch1_en_w;
            cmp2_oe_ff <= ctl_ff[`SVMC_CTL_CMP2_OE] & ~ch2_en_w;
        end
    end

    // output assignments, all from flops
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign ch0_threshold = ch0_thr_ff;
    assign ch1_threshold = lvl_ff;
    assign ch2_source_sel = cfg_ff[`SVMC_CFG_CH2_SRC];
    assign sys_reset_req = sys_rst_ff;
    assign ch1_nmi_req = ch1_nmi_ff;
    assign ch1_mirq_req = ch1_mirq_ff;
    assign ch2_nmi_req = ch2_nmi_ff;
    assign ch2_mirq_req = ch2_mirq_ff;
    assign cmp1_out_pin = cmp1_pin_ff;
    assign cmp1_out_pin_oe = cmp1_oe_ff;
    assign cmp2_out_pin = cmp2_pin_ff;
    assign cmp2_out_pin_oe = cmp2_oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic first_ff; // high in the first cycle after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_ff <= 1'b1;
        end else begin
            first_ff <= 1'b0;
        end
    end

    sequence s_ch1_rise_armed;
        ch1_en_w && cfg_ff[`SVMC_CFG_CH1_BOTH] && rise1_w;
    endsequence

    sequence s_ch1_req;
        ##1 (ch1_nmi_ff || ch1_mirq_ff);
    endsequence

    ctl_reset_zero_a: assert property (first_ff |-> ctl_ff == 8'h00)
        else $error("control register not zero after reset");
    reset_follows_ch0_a: assert property (!sync_w[0] |=> sys_reset_req)
        else $error("reset not asserted for low supply");
    reset_release_a: assert property (sync_w[0] [*2] |-> !sys_reset_req)
        else $error("reset held with supply above threshold");
    ch2_flag_dis_a: assert property (!ch2_en_w |-> ch2_flag_w)
        else $error("ch2 flag not one while disabled");
    pin_enable_a: assert property (cmp1_out_pin_oe |-> $past(ctl_ff[2]) && !$past(ch1_en_w))
        else $error("pin 1 driven without enable");
    pin_polarity_a: assert property (cmp1_out_pin_oe |-> cmp1_out_pin == ($past(sync_w[1]) ^ $past(ctl_ff[0])))
        else $error("pin 1 polarity wrong");
    type_gate_a: assert property (ch1_mirq_req |-> $past(ctl_ff[7]) && $past(ctl_ff[4]))
        else $error("maskable request without gate and type");
    both_edges_a: assert property (s_ch1_rise_armed |-> s_ch1_req)
        else $error("ch1 rising crossing gave no request");
    filter_hold_a: assert property ($changed(lvl2_w) && $past(cfg_ff[8]) |-> $past(tick_w))
        else $error("filtered level changed off a sample tick");
    ch2_source_a: assert property (cfg_ff[2] && cfg_ff[1] && !cfg_ff[8] |=> lvl2_w == $past(sync_w[3]))
        else $error("ch2 not following external pin");

endmodule : svmc_top

// >>> verification/svmc_det_model.sv
// svmc_det_model.sv: behavioural analog detectors and free-running slow oscillator
// assumes: bench gives voltages in millivolts, design gives the threshold selects
`timescale 1ns/1ps

module svmc_det_model #(
    parameter int SLOW_HALF_NS = 100, // slow oscillator half period
    parameter int CH0_BASE = 1000, // arbitrary ch0 level at select 0
    parameter int CH0_STEP = 100, // arbitrary ch0 step per select
    parameter int CH1_BASE = 1500, // arbitrary ch1 level at select 0
    parameter int CH1_STEP = 50, // arbitrary ch1 step per select
    parameter int CH2_LEVEL = 2000 // arbitrary fixed ch2 level
) (
    input wire logic [15:0] vcc_mv,
    input wire logic [15:0] ext_mv,
    input wire logic [1:0] ch0_threshold,
    input wire logic [3:0] ch1_threshold,
    output logic slow_osc_clock,
    output logic ch0_det,
    output logic ch1_det,
    output logic ch2_det_supply,
    output logic ch2_det_ext
);
    ////////////////////////////////////////////////////////////////
    // the oscillator runs free, unrelated to the bus clock
    initial begin
        slow_osc_clock = 1'b0;
        forever #(SLOW_HALF_NS) slow_osc_clock = ~slow_osc_clock;
    end
    ////////////////////////////////////////////////////////////////
    // four strap levels on ch0, sixteen register levels on ch1
    assign ch0_det = int'(vcc_mv) >= CH0_BASE + CH0_STEP * int'(ch0_threshold);
    assign ch1_det = int'(vcc_mv) >= CH1_BASE + CH1_STEP * int'(ch1_threshold);
    // supply and pin detectors both present
    assign ch2_det_supply = int'(vcc_mv) >= CH2_LEVEL;
    assign ch2_det_ext = int'(ext_mv) >= CH2_LEVEL;
endmodule : svmc_det_model

// >>> verification/svmc_tb_top.sv
// svmc_tb_top.sv: self-checking bench for the supply monitor control block
// assumes: one ahb-lite slave, analog side from svmc_det_model
`timescale 1ns/1ps
`include "svmc_map.svh"

`define SVMC_CHK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
end

module svmc_tb_top;
    import svmc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp; // bus control
    logic [31:0] haddr, hwdata, hrdata, rd; // bus data
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] vcc_mv, ext_mv; // analog stimulus
    logic slow_osc_clock, ch0_det, ch1_det, ch2_det_supply, ch2_det_ext;
    logic [1:0] option_config_byte, ch0_threshold;
    logic [3:0] ch1_threshold;
    logic ch2_source_sel, sys_reset_req, ch1_nmi_req, ch1_mirq_req, ch2_nmi_req, ch2_mirq_req;
    logic cmp1_out_pin, cmp1_out_pin_oe, cmp2_out_pin, cmp2_out_pin_oe;
    int mismatches = 0; // failed comparisons
    int check_count = 0; // all comparisons
    int n1n = 0, n1m = 0, n2n = 0, n2m = 0; // request pulse counts

    ////////////////////////////////////////////////////////////////
    // clock, 25 ns period
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    svmc_det_model u_model (.vcc_mv(vcc_mv), .ext_mv(ext_mv), .ch0_threshold(ch0_threshold),
        .ch1_threshold(ch1_threshold), .slow_osc_clock(slow_osc_clock), .ch0_det(ch0_det),
        .ch1_det(ch1_det), .ch2_det_supply(ch2_det_supply), .ch2_det_ext(ch2_det_ext));

    svmc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .slow_osc_clock(slow_osc_clock),
        .option_config_byte(option_config_byte), .ch0_det(ch0_det), .ch1_det(ch1_det),
        .ch2_det_supply(ch2_det_supply), .ch2_det_ext(ch2_det_ext), .ch0_threshold(ch0_threshold),
        .ch1_threshold(ch1_threshold), .ch2_source_sel(ch2_source_sel), .sys_reset_req(sys_reset_req),
        .ch1_nmi_req(ch1_nmi_req), .ch1_mirq_req(ch1_mirq_req), .ch2_nmi_req(ch2_nmi_req),
        .ch2_mirq_req(ch2_mirq_req), .cmp1_out_pin(cmp1_out_pin), .cmp1_out_pin_oe(cmp1_out_pin_oe),
        .cmp2_out_pin(cmp2_out_pin), .cmp2_out_pin_oe(cmp2_out_pin_oe));

    ////////////////////////////////////////////////////////////////
    // count every one-cycle request pulse
    always @(posedge hclk) begin
        if (ch1_nmi_req === 1'b1) n1n++;
        if (ch1_mirq_req === 1'b1) n1m++;
        if (ch2_nmi_req === 1'b1) n2n++;
        if (ch2_mirq_req === 1'b1) n2m++;
    end

    ////////////////////////////////////////////////////////////////
    // one transfer: address phase held until hready, then data phase
    task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] a);
        ahb_xfer(1'b0, a, 32'h0000_0000);
    endtask : rd_reg

    // move the voltages and let the chain settle
    task automatic move(input logic [15:0] v, input logic [15:0] e, input int n);
        @(posedge hclk);
        vcc_mv <= v;
        ext_mv <= e;
        repeat (n) @(posedge hclk);
        #1;
    endtask : move

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        vcc_mv = 16'd3000;
        ext_mv = 16'd3000;
        option_config_byte = 2'b01;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and the strap
        rd_reg(`SVMC_OFS_CTL);
        `SVMC_CHK("ctl reset", 32'h0000_0000, rd)
        `SVMC_CHK("bus response", 2'b10, {hreadyout, hresp})
        `SVMC_CHK("ch0 threshold", 2'b01, ch0_threshold)
        // every control bit writable except the reserved one
        wr_reg(`SVMC_OFS_CTL, 32'h0000_00FF);
        rd_reg(`SVMC_OFS_CTL);
        `SVMC_CHK("ctl readback", 32'h0000_00BF, rd)
        rd_reg(12'h040);
        `SVMC_CHK("unmapped read", 32'h0000_0000, rd)
        wr_reg(`SVMC_OFS_LVL, 32'h0000_0005);
        rd_reg(`SVMC_OFS_LVL);
        `SVMC_CHK("level readback", 32'h0000_0005, rd)
        `SVMC_CHK("ch1 threshold", 4'h5, ch1_threshold)
        // ch0 below its level holds reset, released above
        move(16'd1050, 16'd3000, 10);
        `SVMC_CHK("reset low vcc", 1'b1, sys_reset_req)
        move(16'd1150, 16'd3000, 10);
        `SVMC_CHK("reset released", 1'b0, sys_reset_req)
        move(16'd3000, 16'd3000, 10);
        // comparator pins with monitors off, inverted then plain
        wr_reg(`SVMC_OFS_CTL, 32'h0000_000F);
        move(16'd3000, 16'd3000, 10);
        `SVMC_CHK("cmp1 inverted", 1'b0, cmp1_out_pin)
        `SVMC_CHK("cmp2 inverted", 1'b0, cmp2_out_pin)
        `SVMC_CHK("cmp1 oe", 1'b1, cmp1_out_pin_oe)
        `SVMC_CHK("cmp2 oe", 1'b1, cmp2_out_pin_oe)
        wr_reg(`SVMC_OFS_CTL, 32'h0000_0004);
        move(16'd3000, 16'd3000, 10);
        `SVMC_CHK("cmp1 plain", 1'b1, cmp1_out_pin)
        `SVMC_CHK("cmp2 plain", 1'b1, cmp2_out_pin)
        `SVMC_CHK("cmp2 oe off", 1'b0, cmp2_out_pin_oe)
        // monitor use takes the detector from the comparator pin
        wr_reg(`SVMC_OFS_CFG, 32'h0000_0009);
        move(16'd3000, 16'd3000, 10);
        `SVMC_CHK("cmp1 oe in monitor", 1'b0, cmp1_out_pin_oe)
        // ch1 both edges, gate off gives non-maskable
        move(16'd1600, 16'd3000, 30);
        `SVMC_CHK("ch1 fall nmi", 1, n1n)
        rd_reg(`SVMC_OFS_STAT);
        `SVMC_CHK("ch1 flag low", 1'b0, rd[`SVMC_STAT_CH1_LVL])
        move(16'd3000, 16'd3000, 30);
        `SVMC_CHK("ch1 rise nmi", 2, n1n)
        rd_reg(`SVMC_OFS_STAT);
        `SVMC_CHK("ch1 flag high", 1'b1, rd[`SVMC_STAT_CH1_LVL])
        // type bit first, gate in a separate write
        wr_reg(`SVMC_OFS_CTL, 32'h0000_0010);
        move(16'd1600, 16'd3000, 30);
        `SVMC_CHK("ch1 type gated off", 3, n1n)
        wr_reg(`SVMC_OFS_CTL, 32'h0000_0090);
        move(16'd3000, 16'd3000, 30);
        `SVMC_CHK("ch1 maskable", 1, n1m)
        `SVMC_CHK("ch1 nmi held", 3, n1n)
        // ch2 on the pin, rising edge only, non-maskable
        wr_reg(`SVMC_OFS_CFG, 32'h0000_0046);
        move(16'd3000, 16'd1500, 30);
        `SVMC_CHK("ch2 source pin", 1'b1, ch2_source_sel)
        `SVMC_CHK("ch2 no fall", 0, n2n)
        rd_reg(`SVMC_OFS_STAT);
        `SVMC_CHK("ch2 flag low", 1'b0, rd[`SVMC_STAT_CH2_LVL])
        move(16'd1500, 16'd3000, 30);
        `SVMC_CHK("ch2 rise", 1, n2n)
        `SVMC_CHK("ch2 maskable none", 0, n2m)
        // supply moves do not reach ch2 while it watches the pin
        move(16'd3000, 16'd3000, 30);
        `SVMC_CHK("ch2 pin only", 1, n2n)
        // ch2 both edges, maskable: type bit set while the gate already stands
        wr_reg(`SVMC_OFS_CTL, 32'h0000_00B0);
        wr_reg(`SVMC_OFS_CFG, 32'h0000_0016);
        move(16'd3000, 16'd1500, 30);
        move(16'd3000, 16'd3000, 30);
        `SVMC_CHK("ch2 both maskable", 2, n2m)
        `SVMC_CHK("ch2 nmi unchanged", 1, n2n)
        // disabled ch2 reads above threshold
        wr_reg(`SVMC_OFS_CFG, 32'h0000_0000);
        move(16'd3000, 16'd1500, 30);
        rd_reg(`SVMC_OFS_STAT);
        `SVMC_CHK("ch2 disabled flag", 1'b1, rd[`SVMC_STAT_CH2_LVL])
        `SVMC_CHK("ch2 source supply", 1'b0, ch2_source_sel)
        // ch1 falling only, both filters at divisor 8: glitch dropped, steady fall slow
        wr_reg(`SVMC_OFS_CFG, 32'h0000_0781);
        move(16'd3000, 16'd3000, 400);
        move(16'd1600, 16'd3000, 3);
        move(16'd3000, 16'd3000, 400);
        `SVMC_CHK("glitch filtered", 1, n1m)
        move(16'd1600, 16'd3000, 30);
        `SVMC_CHK("filter delays", 1, n1m)
        repeat (400) @(posedge hclk);
        `SVMC_CHK("filtered fall", 2, n1m)
        move(16'd3000, 16'd3000, 400);
        `SVMC_CHK("ch1 fall only", 2, n1m)
        print_verdict();
    end
endmodule : svmc_tb_top
